// file: inc/lad_defs.svh
// Purpose: Constants for the low-area address decoder
// Assumes: 16-bit multiplexed address/data bus, 8-bit data
// Notes:   Included by the package and design files
`ifndef LAD_DEFS_SVH
`define LAD_DEFS_SVH
// ==================================================================
// Address map
`define LAD_RAMCTL_ADDR   16'h0014
`define LAD_RAMCTL_BIT    6
`define LAD_RAMCTL_RST    8'h00
`define LAD_PORT_KSCAN    4'h0
`define LAD_PORT_KRET_LO  4'h2
`define LAD_PORT_LCD_CS   4'h6
`define LAD_PORT_KRET_HI  4'h8
`define LAD_PORT_LCD_SER  4'hA
`define LAD_PORT_SLEEP    4'hC
`define LAD_REG_TOP       16'h001F
`define LAD_INTRAM_LO     16'h0080
`define LAD_INTRAM_HI     16'h00FF
`define LAD_EXTRAM_LO     16'h0100
`define LAD_RAM0_TOP      16'h07FF
// ==================================================================
// Timing
`define LAD_BUS_DIV       4
`endif

// file: inc/lad_pkg.sv
// Purpose: Types for the low-area address decoder
// Assumes: lad_defs.svh holds all numeric constants
// Notes:   Strobe groups travel as packed structs
`include "lad_defs.svh"
package lad_pkg;
   // ===============================================================
   // Decoded selects, all active high inside the block
   typedef struct packed {
      logic low_area;
      logic rtc;
      logic io_gate;
      logic kscan;
      logic kret_lo;
      logic lcd_cs;
      logic kret_hi;
      logic lcd_ser;
      logic sleep_mask;
      logic int_reg;
      logic int_ram;
      logic ext_ram;
      logic ram0;
      logic ramctl;
   } lad_sel_s;
   typedef enum logic [1:0] {
      LAD_ST_IDLE = 2'b00,
      LAD_ST_ADDR = 2'b01,
      LAD_ST_DATA = 2'b10
   } lad_phase_e;
   typedef struct packed {
      logic [1:0]  div;
      logic        clk_en;
      logic [15:0] addr;
      logic        as_s1;
      logic        as_s2;
      logic        e_s1;
      logic        e_s2;
      logic        as_prev;
      lad_phase_e  phase;
      logic [7:0]  ramctl;
      logic [7:0]  rdata;
      logic        rdata_oe_n;
      lad_sel_s    sel;
      logic [2:0]  bank;
      logic [7:0]  kscan;
      logic        lcd_sck;
      logic        lcd_sd;
   } lad_state_s;
endpackage : lad_pkg

// file: core/lad_addr_map.sv
// Purpose: Combinational map of a latched address to selects
// Assumes: Address is stable for the whole data phase
// Notes:   Selects except low_area are qualified later by the enable strobe
`timescale 1ns/1ps
`include "lad_defs.svh"
module lad_addr_map
   import lad_pkg::*;
(
   input  wire logic [15:0] addr,
   input  wire logic        int_ram_on,
   output lad_sel_s         sel,
   output logic [2:0]       bank
);
   logic low;
   always_comb begin
      sel      = '0;
      low      = (addr[15:7] == 9'h000);
      sel.low_area = low;
      sel.int_reg  = (addr <= `LAD_REG_TOP);
      sel.ramctl   = (addr == `LAD_RAMCTL_ADDR);
      sel.rtc      = low && addr[6];
      sel.io_gate  = low && !addr[6] && addr[5] && !addr[4];
      if (sel.io_gate && !addr[0]) begin
         sel.kscan      = (addr[3:0] == `LAD_PORT_KSCAN);
         sel.kret_lo    = (addr[3:0] == `LAD_PORT_KRET_LO);
         sel.lcd_cs     = (addr[3:0] == `LAD_PORT_LCD_CS);
         sel.kret_hi    = (addr[3:0] == `LAD_PORT_KRET_HI);
         sel.lcd_ser    = (addr[3:0] == `LAD_PORT_LCD_SER);
         sel.sleep_mask = (addr[3:0] == `LAD_PORT_SLEEP);
      end
      sel.int_ram = int_ram_on && addr >= `LAD_INTRAM_LO && addr <= `LAD_INTRAM_HI;
      sel.ext_ram = !low && !sel.int_ram;
      sel.ram0    = sel.ext_ram && addr <= `LAD_RAM0_TOP;
      bank        = low ? 3'h0 : {addr[3], addr[2], addr[1]};
   end
endmodule : lad_addr_map

// file: core/lad_decoder.sv
// Purpose: Low-area decoder for a multiplexed processor bus
// Assumes: Bus pins are asynchronous and pass two flip-flops
// Notes:   All strobes are active low and registered
`timescale 1ns/1ps
`include "lad_defs.svh"
// What this block does
// - Low-area select active when address lines 7 to 15 all low.
// - Low-area select suppresses external RAM chip enable for 0000 to 007F.
// - Clock chip enable low when low area and address bit 6.
// - Low area with bit 6 low, bit 5 high, bit 4 low enables I/O gates for six ports.
// - Port 0020 gives keyboard scan gate and setting switch read.
// - Read of 0022 returns key return lines 0 to 7.
// - Port 0026 strobes LCD select (LCD pointer load).
// - Read of 0028 returns key lines 8,9, power switch, LCD busy.
// - Port 002A outputs LCD serial clock and data.
// - Port 002C strobes sleep-mode interrupt masking.
// - LCD buffers reached only through ports 0026 and 002A.
// - RAM control bit 6 selects internal RAM, no external access.
// - Range 0080 to 00FF steered by RAM control bit 6.
// - 0000 to 001F internal registers, 0020 to 007F external I/O.
// - 0100 to FFFF map to external memory.
// - Bus clock is the oscillator divided by four.
// - Address latched on address strobe, data moved during enable.
// - Low-area select goes out to the expansion connector.
// - Expansion bank from low address bits, bit 0 ignored.
module lad_decoder
   import lad_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  bus_ad_in,
   input  wire logic [15:8] bus_addr_hi,
   output logic [7:0]       bus_ad_out,
   output logic             bus_ad_oe_n,
   input  wire logic        address_strobe,
   input  wire logic        enable_strobe,
   input  wire logic        rd_wr,
   input  wire logic [9:0]  key_return_lines,
   input  wire logic        setting_switch,
   input  wire logic        power_switch_state,
   input  wire logic        lcd_busy,
   output logic             bus_clk_en,
   output logic             low_area_select_n,
   output logic             expansion_connector_low_n,
   output logic [2:0]       expansion_bank,
   output logic             ram_chip_enable_two_n,
   output logic             ext_ram_ce_n,
   output logic             rtc_enable_n,
   output logic [7:0]       key_scan_columns,
   output logic             key_scan_gate_n,
   output logic             lcd_pointer_load_n,
   output logic             lcd_serial_clk,
   output logic             lcd_serial_data,
   output logic             sleep_mask_set_n,
   output logic             int_ram_sel
);
   // ===============================================================
   // State
   lad_state_s q, d;
   lad_sel_s   map_sel;
   logic [2:0] map_bank;
   logic       e_act;
   logic       as_fall;
   logic       rd_s1, rd_s2;
   logic [7:0] ad_s1, ad_s2;
   logic [7:0] hi_s1, hi_s2;
   logic [9:0] kr_s1, kr_s2;
   logic [2:0] misc_s1, misc_s2;

   // ===============================================================
   // Input synchronisers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_s1   <= 1'b1;
         rd_s2   <= 1'b1;
         ad_s1   <= 8'h00;
         ad_s2   <= 8'h00;
         hi_s1   <= 8'h00;
         hi_s2   <= 8'h00;
         kr_s1   <= 10'h000;
         kr_s2   <= 10'h000;
         misc_s1 <= 3'h0;
         misc_s2 <= 3'h0;
      end else begin
         rd_s1   <= rd_wr;
         rd_s2   <= rd_s1;
         ad_s1   <= bus_ad_in;
         ad_s2   <= ad_s1;
         hi_s1   <= bus_addr_hi;
         hi_s2   <= hi_s1;
         kr_s1   <= key_return_lines;
         kr_s2   <= kr_s1;
         misc_s1 <= {setting_switch, power_switch_state, lcd_busy};
         misc_s2 <= misc_s1;
      end
   end

   // ===============================================================
   // Address map
   lad_addr_map u_map (
      .addr       (q.addr),
      .int_ram_on (q.ramctl[`LAD_RAMCTL_BIT]),
      .sel        (map_sel),
      .bank       (map_bank)
   );

   // ===============================================================
   // Next state
   always_comb begin
      d          = q;
      d.as_s1    = address_strobe;
      d.as_s2    = q.as_s1;
      d.e_s1     = enable_strobe;
      d.e_s2     = q.e_s1;
      d.as_prev  = q.as_s2;
      as_fall    = q.as_prev && !q.as_s2;
      e_act      = q.e_s2 && (q.phase == LAD_ST_DATA);
      // Bus clock enable: one pulse every fourth cycle
      d.div      = (q.div == 2'(`LAD_BUS_DIV - 1)) ? 2'h0 : q.div + 2'h1;
      d.clk_en   = (q.div == 2'(`LAD_BUS_DIV - 1));
      case (q.phase)
         LAD_ST_IDLE: begin
            if (q.as_s2) begin
               d.phase = LAD_ST_ADDR;
            end
         end
         LAD_ST_ADDR: begin
            if (as_fall) begin
               d.addr  = {hi_s2, ad_s2};
               d.phase = LAD_ST_DATA;
            end
         end
         LAD_ST_DATA: begin
            if (q.as_s2) begin
               d.phase = LAD_ST_ADDR;
            end
         end
         default: begin
            d.phase = LAD_ST_IDLE;
         end
      endcase
      // Selects other than low_area only live while the enable strobe is active
      d.sel        = e_act ? map_sel : '0;
      d.sel.low_area = (q.phase == LAD_ST_DATA) && map_sel.low_area;
      d.bank       = map_bank;
      // Writes taken at the end of the enable phase
      if (e_act && !q.e_s1 && !rd_s2) begin
         if (map_sel.ramctl) begin
            d.ramctl = ad_s2;
         end
         if (map_sel.kscan) begin
            d.kscan = ad_s2;
         end
      end
      // Serial LCD clock follows the port strobe ANDed with write
      d.lcd_sck = e_act && map_sel.lcd_ser && !rd_s2;
      if (e_act && map_sel.lcd_ser && !rd_s2) begin
         d.lcd_sd = ad_s2[0];
      end
      // Read data
      d.rdata_oe_n = 1'b1;
      d.rdata      = 8'h00;
      if (e_act && rd_s2) begin
         if (map_sel.kret_lo) begin
            d.rdata      = kr_s2[7:0];
            d.rdata_oe_n = 1'b0;
         end else if (map_sel.kret_hi) begin
            d.rdata      = {4'h0, misc_s2[0], misc_s2[1], kr_s2[9:8]};
            d.rdata_oe_n = 1'b0;
         end else if (map_sel.kscan) begin
            d.rdata      = {7'h00, misc_s2[2]};
            d.rdata_oe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q            <= '0;
         q.phase      <= LAD_ST_IDLE;
         q.ramctl     <= `LAD_RAMCTL_RST;
         q.rdata_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ===============================================================
   // Outputs, all straight from flip-flops
   assign bus_clk_en                = q.clk_en;
   assign bus_ad_out                = q.rdata;
   assign bus_ad_oe_n               = q.rdata_oe_n;
   assign low_area_select_n         = !q.sel.low_area;
   assign expansion_connector_low_n = !q.sel.low_area;
   assign expansion_bank            = q.bank;
   assign ram_chip_enable_two_n     = !q.sel.ram0;
   assign ext_ram_ce_n              = !q.sel.ext_ram;
   assign rtc_enable_n              = !q.sel.rtc;
   assign key_scan_columns          = q.kscan;
   assign key_scan_gate_n           = !q.sel.kscan;
   assign lcd_pointer_load_n        = !q.sel.lcd_cs;
   assign lcd_serial_clk            = q.lcd_sck;
   assign lcd_serial_data           = q.lcd_sd;
   assign sleep_mask_set_n          = !q.sel.sleep_mask;
   assign int_ram_sel               = q.ramctl[`LAD_RAMCTL_BIT];
endmodule : lad_decoder

// file: test/lad_decoder_properties.sv
// Purpose: Port checks for the low-area decoder
// Assumes: Strobes active low, registered
// Notes:   Bound to every lad_decoder
`timescale 1ns/1ps
module lad_chk
   import lad_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       enable_strobe,
   input wire logic       rd_wr,
   input wire logic       bus_ad_oe_n,
   input wire logic       bus_clk_en,
   input wire logic       low_area_select_n,
   input wire logic       expansion_connector_low_n,
   input wire logic [2:0] expansion_bank,
   input wire logic       ram_chip_enable_two_n,
   input wire logic       ext_ram_ce_n,
   input wire logic       rtc_enable_n,
   input wire logic       key_scan_gate_n,
   input wire logic       lcd_pointer_load_n,
   input wire logic       sleep_mask_set_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ===============================================================
   // Assertions
   a_bus_clk_div: assert property (bus_clk_en |=> !bus_clk_en [*3] ##1 bus_clk_en)
      else $error("bus clock pulse spacing wrong");
   a_rtc_in_low: assert property (!rtc_enable_n |-> !low_area_select_n)
      else $error("clock chip enabled outside low area");
   a_io_in_low: assert property (!(key_scan_gate_n && lcd_pointer_load_n && sleep_mask_set_n)
      |-> !low_area_select_n) else $error("io gate outside low area");
   a_exp_follows: assert property (expansion_connector_low_n == low_area_select_n)
      else $error("connector select differs");
   a_bank_low_zero: assert property (!low_area_select_n |-> expansion_bank == 3'h0)
      else $error("bank set in low area");
   a_ext_not_low: assert property (!ext_ram_ce_n |-> low_area_select_n)
      else $error("external ram enabled in low area");
   a_two_is_ext: assert property (!ram_chip_enable_two_n |-> !ext_ram_ce_n)
      else $error("ram chip two without external access");
   a_gates_onehot: assert property ($onehot0(~{rtc_enable_n, key_scan_gate_n, lcd_pointer_load_n,
      sleep_mask_set_n, ext_ram_ce_n})) else $error("two selects at once");
   a_strobe_after_e: assert property ($fell(key_scan_gate_n) || $fell(rtc_enable_n) || $fell(sleep_mask_set_n)
      |-> $past(enable_strobe, 2) || $past(enable_strobe, 3) || $past(enable_strobe, 4))
      else $error("strobe without enable");
   a_read_oe_rd: assert property ($fell(bus_ad_oe_n) |-> $past(rd_wr, 3))
      else $error("read drive on write");
   c_rtc_hit: cover property ($fell(rtc_enable_n));
   c_kscan_hit: cover property ($fell(key_scan_gate_n));
   c_read_data: cover property ($fell(bus_ad_oe_n));
   c_ext_hit: cover property ($fell(ext_ram_ce_n));
endmodule : lad_chk
bind lad_decoder lad_chk u_lad_chk (.ref_clk, .nrst, .enable_strobe, .rd_wr, .bus_ad_oe_n, .bus_clk_en,
   .low_area_select_n, .expansion_connector_low_n, .expansion_bank, .ram_chip_enable_two_n, .ext_ram_ce_n,
   .rtc_enable_n, .key_scan_gate_n, .lcd_pointer_load_n, .sleep_mask_set_n);

// file: test/lad_master_model.sv
// Purpose: Bus master driving multiplexed bus cycles
// Assumes: Each phase held at least four cycles
// Notes:   Released lines show the inverse value
`timescale 1ns/1ps
module lad_master
   import lad_pkg::*;
(
   input  wire logic        ref_clk,
   output logic [7:0]       bus_ad_in,
   output logic [15:8]      bus_addr_hi,
   output logic             address_strobe,
   output logic             enable_strobe,
   output logic             rd_wr,
   input  wire logic [7:0]  bus_ad_out
);
   initial begin
      {bus_addr_hi, bus_ad_in} = 16'h0000;
      {address_strobe, enable_strobe, rd_wr} = 3'h1;
   end
   // ===============================================================
   // One bus cycle, slow stretches the address strobe and enable phases
   task automatic cycle(input logic [15:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] rd, input logic [1:0] slow);
      @(negedge ref_clk);
      {bus_addr_hi, bus_ad_in} = a;
      rd_wr = !wr;
      address_strobe = 1'b1;
      repeat (4 + slow) @(negedge ref_clk);
      address_strobe = 1'b0;
      repeat (4) @(negedge ref_clk);
      bus_ad_in = wr ? d : ~a[7:0];
      enable_strobe = 1'b1;
      repeat (5 + slow) @(negedge ref_clk);
      rd = bus_ad_out;
      enable_strobe = 1'b0;
      repeat (4) @(negedge ref_clk);
      rd_wr = 1'b1;
      bus_ad_in = ~bus_ad_in;
      bus_addr_hi = ~bus_addr_hi;
      repeat (4) @(negedge ref_clk);
   endtask : cycle
endmodule : lad_master

// file: test/lad_decoder_test.sv
// Purpose: Self-checking bench for lad_decoder
// Assumes: Master model drives every bus cycle
// Notes:   Random addresses from a fixed seed
`timescale 1ns/1ps
module lad_decoder_test
   import lad_pkg::*;
;
   logic ref_clk, nrst, address_strobe, enable_strobe, rd_wr, setting_switch, power_switch_state, lcd_busy;
   logic [7:0] bus_ad_in, bus_ad_out, key_scan_columns, seen;
   logic [15:8] bus_addr_hi;
   logic [9:0] key_return_lines;
   logic [2:0] expansion_bank;
   logic bus_ad_oe_n, bus_clk_en, low_n, exp_n, two_n, ext_n, rtc_n, ks_n, lcd_n, sclk, sdat, slp_n, iram_q, iram;
   integer seed, fails, tests_run, i;
   integer cycles = 0;
   logic [2:0] en_hist = 3'h0;
   logic oe_seen;
   logic [15:0] dirs [19] = '{16'h0020, 16'h0021, 16'h0022, 16'h0026, 16'h0028, 16'h002A, 16'h002C, 16'h002E,
      16'h0000, 16'h001F, 16'h003F, 16'h0040, 16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h07FF, 16'h0800, 16'hFFFF};
   lad_decoder u_lad_decoder (.ref_clk, .nrst, .bus_ad_in, .bus_addr_hi, .bus_ad_out, .bus_ad_oe_n,
      .address_strobe, .enable_strobe, .rd_wr, .key_return_lines, .setting_switch, .power_switch_state, .lcd_busy,
      .bus_clk_en, .low_area_select_n(low_n), .expansion_connector_low_n(exp_n), .expansion_bank,
      .ram_chip_enable_two_n(two_n), .ext_ram_ce_n(ext_n), .rtc_enable_n(rtc_n), .key_scan_columns,
      .key_scan_gate_n(ks_n), .lcd_pointer_load_n(lcd_n), .lcd_serial_clk(sclk), .lcd_serial_data(sdat),
      .sleep_mask_set_n(slp_n), .int_ram_sel(iram_q));
   lad_master u_lad_master (.ref_clk, .bus_ad_in, .bus_addr_hi, .address_strobe, .enable_strobe, .rd_wr,
      .bus_ad_out);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Selects gathered from enable rise until three edges after its fall
   always @(posedge ref_clk) begin
      en_hist <= {en_hist[1:0], enable_strobe};
      cycles  <= cycles + 1;
      if (address_strobe) begin
         seen    <= 8'h00;
         oe_seen <= 1'b0;
      end else if (enable_strobe || (|en_hist)) begin
         seen    <= seen | {~low_n, ~rtc_n, ~ks_n, ~lcd_n, ~slp_n, sclk, ~two_n, ~ext_n};
         oe_seen <= oe_seen | ~bus_ad_oe_n;
      end
   end
   // ===============================================================
   // Expectations and checks
   function automatic logic [7:0] exp_sel(input logic [15:0] a, input logic wr, input logic ir);
      logic low, ext;
      low = a <= 16'h007F;
      ext = !low && !(ir && a <= 16'h00FF);
      return {low, low && a[6], a == 16'h0020, a == 16'h0026, a == 16'h002C, wr && a == 16'h002A,
              ext && a <= 16'h07FF, ext};
   endfunction : exp_sel
   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic access(input logic [15:0] a, input logic wr, input logic [7:0] d);
      logic [7:0] rd;
      logic       rd_port;
      {key_return_lines, setting_switch, power_switch_state, lcd_busy} = 13'($random(seed));
      u_lad_master.cycle(a, wr, d, rd, 2'($random(seed)));
      if (wr && a == 16'h0014) iram = d[6];
      rd_port = !wr && (a == 16'h0020 || a == 16'h0022 || a == 16'h0028);
      check("selects", seen, exp_sel(a, wr, iram));
      check("read drive", {7'h00, oe_seen}, {7'h00, rd_port});
      check("ram select", {7'h00, iram_q}, {7'h00, iram});
      if (a > 16'h007F) check("bank", {5'h00, expansion_bank}, {5'h00, a[3:1]});
      if (wr && a == 16'h0020) check("columns", key_scan_columns, d);
      if (wr && a == 16'h002A) check("serial data", {7'h00, sdat}, {7'h00, d[0]});
      if (!wr && a == 16'h0020) check("switch", {7'h00, rd[0]}, {7'h00, setting_switch});
      if (!wr && a == 16'h0022) check("keys low", rd, key_return_lines[7:0]);
      if (!wr && a == 16'h0028)
         check("keys high", {4'h0, rd[3:0]}, {4'h0, lcd_busy, power_switch_state, key_return_lines[9:8]});
   endtask : access
   task print_verdict;
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   // ===============================================================
   // Main sequence
   initial begin
      {seed, fails, tests_run, iram, nrst} = {32'h00c8c0ad, 64'h0, 2'b00};
      {key_return_lines, setting_switch, power_switch_state, lcd_busy} = 13'h0000;
      repeat (20) @(negedge ref_clk);
      nrst = 1'b1;
      fork
         begin
            wait (cycles >= 20000);
            fails = fails + 1;
         end
         begin
            repeat (4) @(negedge ref_clk);
            check("idle", {low_n, rtc_n, ks_n, lcd_n, slp_n, two_n, ext_n, bus_ad_oe_n}, 8'hFF);
            for (i = 0; i < 38; i++) access(dirs[i / 2], i[0], 8'($random(seed)));
            access(16'h0014, 1'b1, 8'h40);
            for (i = 13; i < 16; i++) access(dirs[i], 1'b0, 8'h00);
            access(16'h0014, 1'b1, 8'h00);
            access(16'h0080, 1'b1, 8'h5A);
            // Reset in mid-run must drop the internal RAM choice
            access(16'h0014, 1'b1, 8'h40);
            nrst = 1'b0;
            repeat (3) @(negedge ref_clk);
            nrst = 1'b1;
            iram = 1'b0;
            repeat (2) @(negedge ref_clk);
            check("reset", {low_n, rtc_n, ks_n, lcd_n, slp_n, two_n, ext_n, bus_ad_oe_n}, 8'hFF);
            check("ram reset", {7'h00, iram_q}, 8'h00);
            access(16'h0080, 1'b0, 8'h00);
            for (i = 0; i < 60; i++)
               access(i[2] ? 16'($random(seed)) : 16'($random(seed) & 16'h007F), i[0], 8'($random(seed)));
         end
      join_any
      print_verdict();
   end
endmodule : lad_decoder_test
